// ==== hdl/line_controller.sv ====
/*
 One synchronous serial line controller: function decode, channel word
 handshakes, framed transmit with sync, data and cyclic code word, receive with
 sync hunt, response, word assembly and code check, status and summary words.
 Assumes channel signals on the system clock and data set pins asynchronous.
*/
`timescale 1ns/1ps
// Functional notes
// RULE1: Interrupt word while idle sets status bit
// RULE2: Busy while waiting, transmitting or receiving
// RULE3: After sync, hold not-acknowledged until response
// RULE4: Code word mismatch sets cyclic error bit
// RULE5: Receive without carrier, transmit without clear-to-send
// RULE6: Carrier or interlock drop sets sticky bit
// RULE7: Absent or test mode controller flagged
// RULE8: Full-and-receive and empty-and-transmit status bits
// RULE9: Summary word packs three bits per controller
// RULE10: Summary error ORs three failure conditions
// RULE11: Transmit select sends sync, shows empty
// RULE12: Twelfth bit moves holding word to shifter
// RULE13: Data words pass encoder, sent serially
// RULE14: Empty at word end sends code, ends
// RULE15: No sync for 300 us after code
// RULE16: Sync detect enables receive, returns response
// RULE17: Received response clears not-acknowledged bit
// RULE18: Assembled word goes to holding, sets full
// RULE19: Unread holding word overrun ends receive
// RULE20: Idle word triggers code word compare
// RULE21: Computer reads exactly the block length
// RULE22: Deselect on other select or status request
// RULE23: Computer issues codes with controller number
// RULE24: Words move under full/empty handshake
// RULE25: Receive data sampled on clock falling edge
// RULE26: Controller n occupies summary bits 3n..3n+2
// RULE27: Computer polls summary, serves one word
module line_controller
  import line_ctrl_pkg::*;
#(
  parameter int LINE_NUM = 0,
  parameter logic [2:0] EQUIP_NUM = 3'h0,
  parameter logic [11:0] SYNC_WORD = 12'h9b3,
  parameter logic [11:0] IDLE_WORD = 12'hfff,
  parameter logic [2:0] RESP_CODE = 3'h5,
  parameter logic [11:0] CRC_POLY = 12'h80f,
  parameter int GAP_CYC = GAP_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic func_req,
  input wire logic [11:0] func_code,
  output logic func_done,
  input wire logic chan_active,
  output logic chan_connected,
  input wire logic chan_wr_full,
  input wire logic [11:0] chan_wr_data,
  output logic chan_wr_empty,
  output logic chan_rd_full,
  output logic [11:0] chan_rd_data,
  input wire logic chan_rd_empty,
  input wire logic [11:0] peer_summary,
  input wire logic line_present,
  input wire logic test_mode,
  input wire logic transmit_bit_clock,
  input wire logic receive_bit_clock,
  input wire logic receive_data,
  input wire logic carrier_detect,
  input wire logic data_set_ready_interlock,
  input wire logic clear_to_send,
  output logic serial_out,
  output logic send_request,
  output logic [11:0] line_status_word,
  output logic [11:0] all_lines_summary_word
);
  typedef struct packed {
    line_state_t st;
    logic tx_mode;
    logic rx_mode;
    logic chan_sel;
    logic serial_out;
    logic send_request;
    logic [11:0] shift;
    logic [3:0] bitcnt;
    logic [11:0] win;
    logic [1:0] resp_cnt;
    logic [11:0] crc;
    logic [11:0] crc_prev;
    logic [11:0] prev_word;
    logic [11:0] hold;
    logic hold_full;
    logic intr;
    logic unack;
    logic crc_err;
    logic line_drop;
    logic [14:0] gap;
    logic func_done;
    logic chan_conn;
    logic wr_empty;
    logic rd_full;
    logic [11:0] rd_data;
    logic [11:0] status;
    logic [11:0] summary;
  } ctrl_t;
  ctrl_t r, n;

  logic [PIN_COUNT-1:0] pins, lvl, rise, fall;
  logic fifo_in_ready, fifo_valid, push, pop, flush;
  logic [11:0] fifo_data, win_nx;
  logic tx_rise, rx_fall, car, dsr, cts, absent;
  logic fc_take, fc_ours, fc_mine;

  function automatic logic [11:0] crc_word(input logic [11:0] c, input logic [11:0] w);
    logic [11:0] t;
    logic fb;
    t = c;
    fb = 1'b0;
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      fb = w[i] ^ t[11];
      t = {t[10:0], 1'b0} ^ (fb ? CRC_POLY : 12'h000);
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and transmit buffer
  assign pins[PIN_TXC] = transmit_bit_clock;
  assign pins[PIN_RXC] = receive_bit_clock;
  assign pins[PIN_RXD] = receive_data;
  assign pins[PIN_CAR] = carrier_detect;
  assign pins[PIN_DSR] = data_set_ready_interlock;
  assign pins[PIN_CTS] = clear_to_send;
  assign pins[PIN_PRES] = line_present;
  assign pins[PIN_TEST] = test_mode;

  pin_sync #(.W(PIN_COUNT)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .pins(pins),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .flush(flush),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(chan_wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  assign tx_rise = rise[PIN_TXC];
  assign rx_fall = fall[PIN_RXC]; // RULE25
  assign car = lvl[PIN_CAR];
  assign dsr = lvl[PIN_DSR];
  assign cts = lvl[PIN_CTS];
  assign absent = !lvl[PIN_PRES] || lvl[PIN_TEST];
  assign win_nx = {r.win[10:0], lvl[PIN_RXD]};
  assign fc_take = func_req && !r.func_done;
  assign fc_ours = func_code[11:9] == EQUIP_NUM && func_code[8:6] == FC_GROUP;
  assign fc_mine = func_code[2:0] == 3'(LINE_NUM);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    // Function codes
    if (!func_req) begin
      n.func_done = 1'b0;
    end
    if (fc_take) begin
      n.func_done = 1'b1;
      if (fc_ours) begin
        case (func_code[5:3])
          FC_ALL: begin
            if (func_code[2:0] == FC_ALL_NUM) begin
              n.rd_data = r.summary; // RULE9
              n.rd_full = 1'b1;
              n.chan_sel = 1'b0; // RULE22
            end
          end
          FC_STATUS: begin
            if (fc_mine) begin
              n.rd_data = r.status;
              n.rd_full = 1'b1;
              n.chan_sel = 1'b0; // RULE22
            end
          end
          FC_SELECT: n.chan_sel = fc_mine; // RULE22
          FC_CLEAR: begin
            if (fc_mine) begin
              n.st = ST_IDLE;
              n.tx_mode = 1'b0;
              n.rx_mode = 1'b0;
              n.send_request = 1'b0;
              n.serial_out = 1'b1;
              n.unack = 1'b0;
              n.crc_err = 1'b0;
              n.line_drop = 1'b0;
              n.intr = 1'b0;
              n.hold_full = 1'b0;
              n.gap = '0;
              flush = 1'b1;
            end
          end
          FC_SEL_TX: begin
            n.chan_sel = fc_mine; // RULE22
            if (fc_mine) begin
              n.tx_mode = 1'b1; // RULE11
              n.rx_mode = 1'b0;
              n.send_request = 1'b1;
            end
          end
          FC_SEL_RX: begin
            n.chan_sel = fc_mine; // RULE22
            if (fc_mine) begin
              n.rx_mode = 1'b1;
              n.tx_mode = 1'b0;
            end
          end
          FC_CLR_INTR: begin
            if (fc_mine) begin
              n.intr = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    // Channel word handshakes
    n.chan_conn = r.chan_sel && chan_active;
    if (r.rd_full && chan_rd_empty && !fc_take) begin
      n.rd_full = 1'b0; // RULE24
    end
    if (r.chan_conn && r.rx_mode && r.hold_full && !r.rd_full && !chan_rd_empty && !fc_take) begin
      n.rd_data = r.hold; // RULE21
      n.rd_full = 1'b1; // RULE24
      n.hold_full = 1'b0;
    end
    if (r.wr_empty && !chan_wr_full) begin
      n.wr_empty = 1'b0; // RULE24
    end
    if (r.chan_conn && r.tx_mode && chan_wr_full && !r.wr_empty && fifo_in_ready) begin
      push = 1'b1;
      n.wr_empty = 1'b1; // RULE24
    end
    // Response bits and idle marking on the transmit line
    if (tx_rise && !(r.st inside {ST_TX_SYNC, ST_TX_DATA, ST_TX_CODE, ST_TX_GAP})) begin
      if (r.resp_cnt != 2'h0) begin
        n.serial_out = RESP_CODE[r.resp_cnt - 2'h1]; // RULE16
        n.resp_cnt = r.resp_cnt - 2'h1;
      end else begin
        n.serial_out = 1'b1;
      end
    end
    if (rx_fall) begin
      n.win = win_nx;
      if (r.unack && win_nx[RESP_BITS-1:0] == RESP_CODE) begin
        n.unack = 1'b0; // RULE17
      end
    end
    // Line sequencing
    case (r.st)
      ST_IDLE: begin
        if (r.tx_mode && cts) begin
          n.st = ST_TX_SYNC; // RULE11
          n.shift = SYNC_WORD;
          n.bitcnt = '0;
          n.crc = '0;
        end else if (r.rx_mode) begin
          n.st = ST_RX_HUNT;
        end else if (rx_fall && win_nx == INTR_WORD) begin
          n.intr = 1'b1; // RULE1
        end
      end
      ST_TX_SYNC, ST_TX_DATA, ST_TX_CODE: begin
        if (tx_rise) begin
          n.serial_out = r.shift[11]; // RULE13
          n.shift = {r.shift[10:0], 1'b0};
          n.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == BIT_LAST) begin
            n.bitcnt = '0;
            if (r.st == ST_TX_SYNC) begin
              n.unack = 1'b1; // RULE3
            end
            if (r.st == ST_TX_CODE) begin
              n.st = ST_TX_GAP; // RULE15
              n.gap = 15'(GAP_CYC - 1);
              n.shift = IDLE_WORD;
              n.tx_mode = 1'b0;
              n.send_request = 1'b0;
            end else if (fifo_valid) begin
              pop = 1'b1; // RULE12
              n.shift = fifo_data;
              n.crc = crc_word(r.crc, fifo_data); // RULE13
              n.st = ST_TX_DATA;
            end else begin
              n.shift = r.crc; // RULE14
              n.st = ST_TX_CODE;
            end
          end
        end
      end
      ST_TX_GAP: begin
        if (tx_rise) begin
          n.serial_out = r.shift[11];
          n.shift = {r.shift[10:0], r.shift[11]};
        end
        if (r.gap == '0) begin
          n.st = ST_IDLE;
        end else begin
          n.gap = r.gap - 15'h1; // RULE15
        end
      end
      ST_RX_HUNT: begin
        if (!r.rx_mode) begin
          n.st = ST_IDLE;
        end else if (rx_fall && win_nx == SYNC_WORD) begin
          n.st = ST_RX_DATA; // RULE16
          n.bitcnt = '0;
          n.crc = '0;
          n.resp_cnt = 2'(RESP_BITS);
        end
      end
      ST_RX_DATA: begin
        if (!r.rx_mode) begin
          n.st = ST_IDLE;
        end else if (rx_fall) begin
          n.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == BIT_LAST) begin
            n.bitcnt = '0;
            if (win_nx == IDLE_WORD) begin
              if (r.prev_word != r.crc_prev) begin
                n.crc_err = 1'b1; // RULE20 RULE4
              end
              n.st = ST_IDLE;
              n.rx_mode = 1'b0;
            end else if (r.hold_full) begin
              n.st = ST_IDLE; // RULE19
              n.rx_mode = 1'b0;
            end else begin
              n.hold = win_nx; // RULE18
              n.hold_full = 1'b1;
              n.prev_word = win_nx;
              n.crc_prev = r.crc;
              n.crc = crc_word(r.crc, win_nx);
            end
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (fall[PIN_CAR] || fall[PIN_DSR]) begin
      n.line_drop = 1'b1; // RULE6
    end
    // Status and summary words
    n.status = '0;
    n.status[STB_INTR] = r.intr;
    n.status[STB_BUSY] = r.st != ST_IDLE || r.tx_mode || r.rx_mode; // RULE2
    n.status[STB_UNACK] = r.unack; // RULE3
    n.status[STB_CRC] = r.crc_err; // RULE4
    n.status[STB_NOCAR] = r.rx_mode && !car; // RULE5
    n.status[STB_NOCTS] = r.tx_mode && !cts; // RULE5
    n.status[STB_DROP] = r.line_drop; // RULE6
    n.status[STB_ABSENT] = absent; // RULE7
    n.status[STB_FULL_RX] = r.rx_mode && r.hold_full; // RULE8
    n.status[STB_EMPTY_TX] = r.tx_mode && !fifo_valid; // RULE8
    n.summary = peer_summary;
    n.summary[LINE_NUM*SUM_STRIDE+SUM_FULL_RX] = r.rx_mode && r.hold_full; // RULE26
    n.summary[LINE_NUM*SUM_STRIDE+SUM_EMPTY_TX] = r.tx_mode && !fifo_valid; // RULE26
    n.summary[LINE_NUM*SUM_STRIDE+SUM_ERR] = (r.rx_mode && !car) || (r.tx_mode && !cts) || r.crc_err; // RULE10
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.serial_out <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign func_done = r.func_done;
  assign chan_connected = r.chan_conn;
  assign chan_wr_empty = r.wr_empty;
  assign chan_rd_full = r.rd_full;
  assign chan_rd_data = r.rd_data;
  assign serial_out = r.serial_out;
  assign send_request = r.send_request;
  assign line_status_word = r.status;
  assign all_lines_summary_word = r.summary;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence sync_last_bit;
    r.st == ST_TX_SYNC && tx_rise && r.bitcnt == BIT_LAST;
  endsequence
  sequence rx_word_done;
    r.st == ST_RX_DATA && r.rx_mode && rx_fall && r.bitcnt == BIT_LAST;
  endsequence

  intr_word_set_a: assert property (r.st == ST_IDLE && !r.tx_mode && !r.rx_mode && rx_fall // RULE1
    && win_nx == INTR_WORD |=> r.intr) else $error("interrupt word not flagged");
  busy_tx_a: assert property (r.st == ST_TX_DATA |=> r.status[STB_BUSY]) // RULE2
    else $error("busy missing while transmitting");
  sync_unack_a: assert property (sync_last_bit ##1 !rx_fall [*2] |-> r.unack && r.status[STB_UNACK]) // RULE3
    else $error("sync not acknowledged bit missing");
  code_check_a: assert property (rx_word_done and (win_nx == IDLE_WORD && r.prev_word != r.crc_prev) // RULE20
    |=> r.crc_err ##1 r.status[STB_CRC]) else $error("code mismatch not flagged");
  no_carrier_a: assert property (r.rx_mode && !car && !fc_take |=> r.status[STB_NOCAR]) // RULE5
    else $error("receive without carrier not flagged");
  line_drop_a: assert property (fall[PIN_CAR] |=> r.line_drop ##1 r.status[STB_DROP]) // RULE6
    else $error("carrier drop not flagged");
  overrun_end_a: assert property (rx_word_done and (win_nx != IDLE_WORD && r.hold_full) // RULE19
    |=> r.st == ST_IDLE && !r.rx_mode) else $error("overrun did not end receive");
  word_full_a: assert property (rx_word_done and (win_nx != IDLE_WORD && !r.hold_full) // RULE18
    |=> r.hold_full && r.hold == $past(win_nx)) else $error("assembled word not held");
  gap_hold_a: assert property (r.st == ST_TX_GAP && r.gap != '0 && !fc_take |=> r.st == ST_TX_GAP) // RULE15
    else $error("sync allowed inside gap");
  deselect_a: assert property (fc_take && fc_ours && func_code[5:3] == FC_ALL // RULE22
    && func_code[2:0] == FC_ALL_NUM |=> !r.chan_sel && r.rd_full) else $error("status-all kept selection");
endmodule // line_controller

// ==== pkg/line_ctrl_pkg.sv ====
/*
 Shared constants of the serial line controller: word size, timing, status bit
 positions, function code fields and pin indices.
 Assumes a 100 MHz system clock.
*/
package line_ctrl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_BITS = 12;
  localparam int WORD_US = 300;
  localparam int GAP_US = 300;
  localparam int GAP_CYCLES = GAP_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 16;
  localparam int RESP_BITS = 3;
  localparam logic [3:0] BIT_LAST = 4'hb;
  localparam logic [11:0] INTR_WORD = 12'hf92;
  // Line status word bit positions
  localparam int STB_INTR = 0;
  localparam int STB_BUSY = 1;
  localparam int STB_UNACK = 2;
  localparam int STB_CRC = 3;
  localparam int STB_NOCAR = 4;
  localparam int STB_NOCTS = 5;
  localparam int STB_DROP = 6;
  localparam int STB_ABSENT = 7;
  localparam int STB_FULL_RX = 10;
  localparam int STB_EMPTY_TX = 11;
  // Summary word slot layout
  localparam int SUM_FULL_RX = 0;
  localparam int SUM_EMPTY_TX = 1;
  localparam int SUM_ERR = 2;
  localparam int SUM_STRIDE = 3;
  // Function code fields
  localparam logic [2:0] FC_GROUP = 3'h5;
  localparam logic [2:0] FC_ALL = 3'h0;
  localparam logic [2:0] FC_ALL_NUM = 3'h4;
  localparam logic [2:0] FC_STATUS = 3'h1;
  localparam logic [2:0] FC_SELECT = 3'h2;
  localparam logic [2:0] FC_CLEAR = 3'h3;
  localparam logic [2:0] FC_SEL_TX = 3'h4;
  localparam logic [2:0] FC_SEL_RX = 3'h5;
  localparam logic [2:0] FC_CLR_INTR = 3'h6;
  // Pin vector indices
  localparam int PIN_TXC = 0;
  localparam int PIN_RXC = 1;
  localparam int PIN_RXD = 2;
  localparam int PIN_CAR = 3;
  localparam int PIN_DSR = 4;
  localparam int PIN_CTS = 5;
  localparam int PIN_PRES = 6;
  localparam int PIN_TEST = 7;
  localparam int PIN_COUNT = 8;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_TX_SYNC = 7'h02,
    ST_TX_DATA = 7'h04,
    ST_TX_CODE = 7'h08,
    ST_TX_GAP = 7'h10,
    ST_RX_HUNT = 7'h20,
    ST_RX_DATA = 7'h40
  } line_state_t;
endpackage

// ==== hdl/pin_sync.sv ====
/*
 Two flip-flop synchroniser for a vector of pins, with rise and fall pulses
 taken from the synchronised level.
 Assumes asynchronous pins and one system clock.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;
  sync_t r, n;

  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  genvar i;
  for (i = 0; i < W; i++) begin : g_edge
    assign level[i] = r.s2[i];
    assign rise[i] = r.s2[i] & ~r.s3[i];
    assign fall[i] = r.s3[i] & ~r.s2[i];
  end
endmodule // pin_sync

// ==== hdl/word_fifo.sv ====
/*
 Synchronous FIFO with valid/ready on both sides and a flush.
 Assumes DEPTH is a power of two.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ptr_t;
  ptr_t r, n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (r.wp[AW] == r.rp[AW]) || (r.wp[AW-1:0] != r.rp[AW-1:0]);
  assign out_valid = r.wp != r.rp;
  assign out_data = mem[r.rp[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    n = r;
    if (flush) begin
      n.rp = r.wp;
    end else begin
      if (push) begin
        n.wp = r.wp + 1'b1;
      end
      if (pop) begin
        n.rp = r.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clock) begin
    if (push && !flush) begin
      mem[r.wp[AW-1:0]] <= in_data;
    end
  end
endmodule // word_fifo

// ==== sim/data_set_model.sv ====
/*
 Data set model: bit clocks, receive line, clear-to-send, capture of sent bits.
 Assumes the controller's line pins face it.
*/
`timescale 1ns/1ps
module data_set_model (
  input wire logic clk_en,
  input wire logic car_on,
  input wire logic serial_out,
  input wire logic send_request,
  output logic transmit_bit_clock,
  output logic receive_bit_clock,
  output logic receive_data,
  output logic carrier_detect,
  output logic data_set_ready_interlock,
  output logic clear_to_send
);
  logic rx_q[$];
  logic tx_q[$];
  assign clear_to_send = send_request;
  assign carrier_detect = car_on;
  assign data_set_ready_interlock = 1'b1;
  // Bit clocks stand still while disabled
  initial begin
    transmit_bit_clock = 1'b0;
    receive_bit_clock = 1'b0;
    receive_data = 1'b1;
    forever begin
      #40;
      if (clk_en) begin
        transmit_bit_clock = ~transmit_bit_clock;
        receive_bit_clock = ~receive_bit_clock;
      end
    end
  end
  // Line changes on rise, marking when nothing queued
  always @(posedge receive_bit_clock) begin
    receive_data <= (rx_q.size() > 0) ? rx_q.pop_front() : 1'b1;
  end
  always @(negedge transmit_bit_clock) begin
    tx_q.push_back(serial_out);
  end
  task automatic send(input logic [11:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) rx_q.push_back(w[i]);
  endtask
endmodule // data_set_model

// ==== sim/tb_top.sv ====
/*
 Bench of the line controller: functions, channel words, framing, status words.
 Assumes the data set model on the line side.
*/
`timescale 1ns/1ps
module tb_top;
  import line_ctrl_pkg::*;
  localparam logic [11:0] SYNC = 12'h9b3;
  localparam logic [11:0] PEER = 12'h5a8;
  logic clock, nrst, func_req, func_done, chan_active, chan_connected, chan_wr_full, chan_wr_empty;
  logic chan_rd_full, chan_rd_empty, line_present, test_mode, clk_en, car_on, transmit_bit_clock;
  logic receive_bit_clock, receive_data, carrier_detect, data_set_ready_interlock, clear_to_send;
  logic serial_out, send_request;
  logic [11:0] func_code, chan_wr_data, chan_rd_data, line_status_word, all_lines_summary_word;
  int miscompares = 0;
  int compares = 0;
  line_controller #(.SYNC_WORD(SYNC), .GAP_CYC(40)) DUT (.clock, .nrst, .func_req, .func_code, .func_done,
    .chan_active, .chan_connected, .chan_wr_full, .chan_wr_data, .chan_wr_empty, .chan_rd_full, .chan_rd_data,
    .chan_rd_empty, .peer_summary(PEER), .line_present, .test_mode, .transmit_bit_clock, .receive_bit_clock,
    .receive_data, .carrier_detect, .data_set_ready_interlock, .clear_to_send, .serial_out, .send_request,
    .line_status_word, .all_lines_summary_word);
  data_set_model dset (.clk_en, .car_on, .serial_out, .send_request, .transmit_bit_clock, .receive_bit_clock,
    .receive_data, .carrier_detect, .data_set_ready_interlock, .clear_to_send);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string name, input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return func_done;
      1: return chan_wr_empty;
      2: return chan_rd_full;
      default: return send_request;
    endcase
  endfunction
  task automatic ws(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v && n < 20000) begin
      @(negedge clock);
      n++;
    end
    chk("handshake", {11'h0, sig(k)}, {11'h0, v});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic fn(input logic [2:0] sub, input logic [2:0] num);
    func_code = {3'h0, FC_GROUP, sub, num};
    func_req = 1'b1;
    ws(0, 1'b1);
    func_req = 1'b0;
    ws(0, 1'b0);
  endtask
  task automatic rd(input string name, input logic [11:0] exp, input logic [11:0] m);
    ws(2, 1'b1);
    chk(name, chan_rd_data & m, exp);
    chan_rd_empty = 1'b1;
    ws(2, 1'b0);
    chan_rd_empty = 1'b0;
    idle(1);
  endtask
  task automatic wr(input logic [11:0] w);
    chan_wr_data = w;
    chan_wr_full = 1'b1;
    ws(1, 1'b1);
    chan_wr_full = 1'b0;
    ws(1, 1'b0);
  endtask
  function automatic logic [11:0] crc(input logic [11:0] c, input logic [11:0] w);
    for (int i = 11; i >= 0; i--) c = {c[10:0], 1'b0} ^ ((c[11] ^ w[i]) ? 12'h80f : 12'h000);
    return c;
  endfunction
  function automatic logic [11:0] bits(input int p);
    for (int i = 0; i < 12; i++) bits[11 - i] = dset.tx_q[p + i];
  endfunction
  task automatic t_absent;
    chk("marking", {11'h0, serial_out}, 12'h001);
    test_mode = 1'b1;
    idle(8);
    chk("test mode", line_status_word & 12'h080, 12'h080);
    test_mode = 1'b0;
    line_present = 1'b0;
    idle(8);
    chk("absent", line_status_word & 12'h080, 12'h080);
    line_present = 1'b1;
    idle(8);
    chk("status idle", line_status_word, 12'h000);
  endtask
  task automatic t_tx;
    int p;
    logic [11:0] c;
    c = 12'h000;
    p = 0;
    dset.tx_q.delete();
    fn(FC_SEL_TX, 3'h0);
    idle(8);
    chk("tx select", line_status_word & 12'h802, 12'h802);
    chk("request", {11'h0, send_request}, 12'h001);
    fn(FC_ALL, FC_ALL_NUM);
    rd("tx summary", PEER & 12'hff8 | 12'h002, 12'hfff);
    fn(FC_SELECT, 3'h0);
    for (int i = 0; i < 16; i++) wr(12'h0f0 + 12'(i * 9));
    chk("fifo full", line_status_word & 12'h800, 12'h000);
    chan_wr_full = 1'b1;
    idle(12);
    chk("refused", {11'h0, chan_wr_empty}, 12'h000);
    chan_wr_full = 1'b0;
    clk_en = 1'b1;
    idle(150);
    chk("unacked", line_status_word & 12'h004, 12'h004);
    dset.send(12'h005, 3);
    idle(80);
    chk("acked", line_status_word & 12'h004, 12'h000);
    ws(3, 1'b0);
    idle(300);
    while (p < dset.tx_q.size() - 12 && bits(p) !== SYNC) p++;
    chk("sync", bits(p), SYNC);
    for (int k = 0; k < 16; k++) begin
      chk("tx word", bits(p + 12 * k + 12), 12'h0f0 + 12'(k * 9));
      c = crc(c, 12'h0f0 + 12'(k * 9));
    end
    chk("code word", bits(p + 204), c);
    chk("gap", bits(p + 216), 12'hfff);
  endtask
  task automatic t_rx(input logic bad, input logic [11:0] a, input logic [11:0] b);
    logic [11:0] c;
    int p;
    c = crc(crc(12'h000, a), b);
    p = 0;
    dset.tx_q.delete();
    fn(FC_SEL_RX, 3'h0);
    fn(FC_ALL, FC_ALL_NUM);
    rd("rx poll", PEER & 12'hff8, 12'hfff);
    dset.send(SYNC, 12);
    dset.send(a, 12);
    dset.send(b, 12);
    dset.send(c ^ {11'h0, bad}, 12);
    dset.send(12'hfff, 12);
    idle(8);
    chk("rx busy", line_status_word & 12'h002, 12'h002);
    for (int i = 0; i < 400 && line_status_word[STB_FULL_RX] !== 1'b1; i++) idle(1);
    chk("full rx", line_status_word & 12'h400, 12'h400);
    fn(FC_ALL, FC_ALL_NUM);
    rd("rx summary", PEER & 12'hff8 | 12'h001, 12'hfff);
    fn(FC_SELECT, 3'h0);
    rd("rx word", a, 12'hfff);
    rd("rx word", b, 12'hfff);
    rd("rx code", c ^ {11'h0, bad}, 12'hfff);
    idle(200);
    chk("code check", line_status_word & 12'h008, {8'h0, bad, 3'h0});
    while (p < dset.tx_q.size() - 2 && dset.tx_q[p] !== 1'b0) p++;
    chk("response", {9'h0, dset.tx_q[p - 1], dset.tx_q[p], dset.tx_q[p + 1]}, 12'h005);
    chk("connected", {11'h0, chan_connected}, 12'h001);
    fn(FC_ALL, FC_ALL_NUM);
    rd("summary", PEER & 12'hff8 | {9'h0, bad, 2'b00}, 12'hfff);
    chk("deselect", {11'h0, chan_connected}, 12'h000);
  endtask
  task automatic t_fail;
    dset.send(INTR_WORD, 12);
    idle(150);
    chk("interrupt", line_status_word & 12'h001, 12'h001);
    fn(FC_CLR_INTR, 3'h0);
    idle(4);
    chk("interrupt clear", line_status_word & 12'h001, 12'h000);
    fn(FC_CLEAR, 3'h0);
    car_on = 1'b0;
    fn(FC_SEL_RX, 3'h0);
    idle(8);
    chk("no carrier", line_status_word & 12'h050, 12'h050);
    fn(FC_STATUS, 3'h0);
    rd("status read", 12'h052, 12'hfff);
    chk("status deselect", {11'h0, chan_connected}, 12'h000);
    fn(FC_ALL, FC_ALL_NUM);
    rd("summary error", 12'h004, 12'h004);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    func_req = 1'b0;
    func_code = 12'h000;
    chan_active = 1'b1;
    chan_wr_full = 1'b0;
    chan_wr_data = 12'h000;
    chan_rd_empty = 1'b0;
    line_present = 1'b1;
    test_mode = 1'b0;
    clk_en = 1'b0;
    car_on = 1'b1;
    idle(20);
    nrst = 1'b1;
    idle(4);
    t_absent;
    t_tx;
    t_rx(1'b0, 12'h7e1, 12'h0c3);
    t_rx(1'b1, 12'h2a5, 12'h913);
    t_fail;
    end_of_test;
  end
  initial begin
    #300000;
    miscompares++;
    end_of_test;
  end
endmodule // tb_top
